// [sxr_consts.svh]
// timing counts, field positions and opcode patterns for the instruction executor
`ifndef SXR_CONSTS_SVH
`define SXR_CONSTS_SVH
`define SXR_OPC_RETURN 14'h0012
`define SXR_OPC_RETURN_MASK 14'h3FFE
`define SXR_OPC_ROTL 14'h0D00
`define SXR_OPC_ROTR 14'h0C00
`define SXR_OPC_ROT_MASK 14'h3F00
`define SXR_OPC_SLEEP 14'h0063
`define SXR_OPC_LITSUB 14'h3C00
`define SXR_OPC_LITSUB_MASK 14'h3F00
`define SXR_DEST_BIT 7
`define SXR_RETURN_CYCLES 2'h2
`define SXR_PC_RESET 15'h0000
`define SXR_W_RESET 8'h00
// carry, nibble carry and zero clear; time-out and power-down set
`define SXR_FLAGS_RESET 5'h03
`endif

// [sxr_exec.sv]
// executor for return, rotate through carry, sleep and subtract-from-literal
`timescale 1ns/1ps
`include "sxr_consts.svh"
// Overview of operation
// [RULE1] return opcode pops stack and loads popped value into program counter
// [RULE2] return takes two instruction cycles so the pipeline refills
// [RULE3] rotate left: bits up, bit 7 to carry, old carry to bit 0
// [RULE4] rotate right: bits down, bit 0 to carry, old carry to bit 7
// [RULE5] rotate destination bit 0 writes W, 1 writes the file register
// [RULE6] sleep clears power-down status flag
// [RULE7] sleep sets time-out status flag
// [RULE8] sleep clears watchdog counter and its prescaler
// [RULE9] subtract-from-literal computes literal minus W into W
// [RULE10] carry is 1 when W not above literal; nibble carry is 1 when W's low nibble not above the literal's
// [RULE11] subtract sets zero on zero result; rotates change only carry
module sxr_exec
    import sxr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic [13:0] i_opcode,
    input wire logic [7:0] i_file_data,
    input wire logic [14:0] i_stack_head_value,
    output logic o_pop,
    output logic o_fetch_stall,
    output logic [14:0] o_pc,
    output logic o_pc_load,
    output logic [7:0] o_w,
    output sxr_fwrite_s o_fwrite,
    output sxr_flags_s o_flags,
    output logic o_watchdog_clear,
    output logic o_sleep
);

    // ************************************
    // decode
    // ************************************
    // the return pattern ignores its low bit; rotates ignore their operand bits
    function automatic sxr_op_e decode(input logic [13:0] op);
        if ((op & `SXR_OPC_RETURN_MASK) == `SXR_OPC_RETURN)
            return SXR_OP_RETURN; // RULE1
        else if ((op & `SXR_OPC_ROT_MASK) == `SXR_OPC_ROTL)
            return SXR_OP_ROTL; // RULE3
        else if ((op & `SXR_OPC_ROT_MASK) == `SXR_OPC_ROTR)
            return SXR_OP_ROTR; // RULE4
        else if (op == `SXR_OPC_SLEEP)
            return SXR_OP_SLEEP; // RULE6
        else if ((op & `SXR_OPC_LITSUB_MASK) == `SXR_OPC_LITSUB)
            return SXR_OP_LITSUB; // RULE9
        else
            return SXR_OP_NONE;
    endfunction

    // rotate through carry: the top bit of the answer is the carry that falls out
    function automatic logic [8:0] rot_carry(input logic lft, input logic [7:0] f,
        input logic c);
        if (lft)
            return {f, c}; // RULE3
        else
            return {f[0], c, f[7:1]}; // RULE4
    endfunction

    // k minus w with a ninth bit; no borrow out means carry set
    function automatic logic [10:0] lit_sub(input logic [7:0] k, input logic [7:0] w);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'h0, k} - {1'h0, w};
        low = {1'h0, k[3:0]} - {1'h0, w[3:0]};
        // carry, nibble carry, zero, then the difference
        return {~full[8], ~low[4], full[7:0] == 8'h00, full[7:0]}; // RULE10 RULE11
    endfunction

    sxr_op_e op;
    logic take;
    logic [8:0] rot;
    logic [10:0] sub;
    logic [1:0] ret_left_q, ret_left_d;
    logic pop_q, pop_d;
    logic stall_q, stall_d;
    logic [14:0] pc_q, pc_d;
    logic pc_load_q, pc_load_d;
    logic [7:0] w_q, w_d;
    sxr_fwrite_s fw_q, fw_d;
    sxr_flags_s fl_q, fl_d;
    logic wdc_q, wdc_d;
    logic sleep_q, sleep_d;

    assign op = decode(i_opcode);
    // a slot still owed to a return refill is dropped, not queued
    assign take = i_valid && (ret_left_q == 2'h0); // RULE2
    assign rot = rot_carry(op == SXR_OP_ROTL, i_file_data, fl_q.carry);
    assign sub = lit_sub(i_opcode[7:0], w_q); // RULE9

    // ************************************
    // return and refill
    // ************************************
    always_comb
    begin
        ret_left_d = (ret_left_q != 2'h0) ? ret_left_q - 2'h1 : 2'h0;
        pop_d = 1'h0;
        pc_d = pc_q;
        pc_load_d = 1'h0;
        if (take && op == SXR_OP_RETURN)
        begin
            ret_left_d = `SXR_RETURN_CYCLES - 2'h1; // RULE2
            pop_d = 1'h1; // RULE1
            pc_d = i_stack_head_value; // RULE1
            pc_load_d = 1'h1; // RULE1
        end
        // the stall covers every cycle still owed to the refill
        stall_d = (ret_left_d != 2'h0); // RULE2
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            ret_left_q <= 2'h0;
            pop_q <= 1'h0;
            stall_q <= 1'h0;
            pc_q <= `SXR_PC_RESET;
            pc_load_q <= 1'h0;
        end
        else
        begin
            ret_left_q <= ret_left_d;
            pop_q <= pop_d;
            stall_q <= stall_d;
            pc_q <= pc_d;
            pc_load_q <= pc_load_d;
        end
    end

    // ************************************
    // working register, file write and flags
    // ************************************
    always_comb
    begin
        w_d = w_q;
        fw_d = '0;
        fl_d = fl_q;
        if (take)
        begin
            unique case (op)
                SXR_OP_ROTL, SXR_OP_ROTR:
                begin
                    // only carry moves for rotates
                    fl_d.carry = rot[8]; // RULE3 RULE4 RULE11
                    if (i_opcode[`SXR_DEST_BIT]) // RULE5
                    begin
                        fw_d.en = 1'h1;
                        fw_d.addr = i_opcode[6:0];
                        fw_d.data = rot[7:0];
                    end
                    else
                        w_d = rot[7:0]; // RULE5
                end
                SXR_OP_SLEEP:
                begin
                    fl_d.powerdown = 1'h0; // RULE6
                    fl_d.timeout = 1'h1; // RULE7
                end
                SXR_OP_LITSUB:
                begin
                    w_d = sub[7:0]; // RULE9
                    fl_d.carry = sub[10]; // RULE10
                    fl_d.nibble = sub[9]; // RULE10
                    fl_d.zero = sub[8]; // RULE11
                end
                SXR_OP_RETURN, SXR_OP_NONE:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            w_q <= `SXR_W_RESET;
            fw_q <= '0;
            fl_q <= `SXR_FLAGS_RESET;
        end
        else
        begin
            w_q <= w_d;
            fw_q <= fw_d;
            fl_q <= fl_d;
        end
    end

    // ************************************
    // sleep entry
    // ************************************
    // the watchdog itself lives outside; this pulse clears it and its prescaler
    always_comb
    begin
        wdc_d = 1'h0;
        sleep_d = 1'h0;
        if (take && op == SXR_OP_SLEEP)
        begin
            wdc_d = 1'h1; // RULE8
            sleep_d = 1'h1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            wdc_q <= 1'h0;
            sleep_q <= 1'h0;
        end
        else
        begin
            wdc_q <= wdc_d;
            sleep_q <= sleep_d;
        end
    end

    // ************************************
    // outputs
    // ************************************
    assign o_pop = pop_q;
    assign o_fetch_stall = stall_q;
    assign o_pc = pc_q;
    assign o_pc_load = pc_load_q;
    assign o_w = w_q;
    assign o_fwrite = fw_q;
    assign o_flags = fl_q;
    assign o_watchdog_clear = wdc_q;
    assign o_sleep = sleep_q;

endmodule // sxr_exec

// [sxr_exec_monitor.sv]
// checker for the instruction executor ports
`timescale 1ns/1ps
module sxr_exec_monitor
    import sxr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic [13:0] i_opcode,
    input wire logic [7:0] i_file_data,
    input wire logic [14:0] i_stack_head_value,
    input wire logic o_pop,
    input wire logic o_fetch_stall,
    input wire logic [14:0] o_pc,
    input wire logic o_pc_load,
    input wire logic [7:0] o_w,
    input wire sxr_fwrite_s o_fwrite,
    input wire sxr_flags_s o_flags,
    input wire logic o_watchdog_clear,
    input wire logic o_sleep
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // the bubble slot after a return is never taken
    wire logic tk = i_valid && !o_fetch_stall;
    ret_pop_a: assert property (tk && i_opcode[13:1] == 13'h0009 |=> o_pop && o_pc_load
        && o_fetch_stall && o_pc == $past(i_stack_head_value)) else $error("bad return");
    ret_gap_a: assert property (o_fetch_stall |=> !o_fetch_stall && !o_pop)
        else $error("bad bubble");
    rot_left_a: assert property (tk && i_opcode[13:7] == 7'h1B |=> o_fwrite.en
        && o_fwrite.data == {$past(i_file_data[6:0]), $past(o_flags.carry)}
        && o_flags.carry == $past(i_file_data[7])) else $error("bad left");
    rot_right_a: assert property (tk && i_opcode[13:7] == 7'h18 |=> !o_fwrite.en
        && o_w == {$past(o_flags.carry), $past(i_file_data[7:1])}
        && o_flags.carry == $past(i_file_data[0])) else $error("bad right");
    rot_keep_a: assert property (tk && i_opcode[13:9] == 5'h06 |=> $stable(o_flags[3:0]))
        else $error("bad flags");
    sleep_entry_a: assert property (tk && i_opcode == 14'h0063 |=> o_sleep && o_watchdog_clear
        && o_flags.timeout && !o_flags.powerdown) else $error("bad sleep");
    sub_val_a: assert property (tk && i_opcode[13:8] == 6'h3C |=>
        o_w == $past(i_opcode[7:0]) - $past(o_w)
        && o_flags.carry == ($past(o_w) <= $past(i_opcode[7:0]))) else $error("bad sub");
    sub_flag_a: assert property (tk && i_opcode[13:8] == 6'h3C |=>
        o_flags.zero == (o_w == 8'h00)
        && o_flags.nibble == ($past(o_w[3:0]) <= $past(i_opcode[3:0]))) else $error("bad sub");
    cover property (o_pop);
    cover property (o_sleep);
    cover property (o_fwrite.en);
endmodule // sxr_exec_monitor
bind sxr_exec sxr_exec_monitor i_sxr_exec_monitor (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_valid(i_valid),
    .i_opcode(i_opcode),
    .i_file_data(i_file_data),
    .i_stack_head_value(i_stack_head_value),
    .o_pop(o_pop),
    .o_fetch_stall(o_fetch_stall),
    .o_pc(o_pc),
    .o_pc_load(o_pc_load),
    .o_w(o_w),
    .o_fwrite(o_fwrite),
    .o_flags(o_flags),
    .o_watchdog_clear(o_watchdog_clear),
    .o_sleep(o_sleep)
);

// [sxr_pkg.sv]
// types shared by the instruction executor
package sxr_pkg;
    typedef enum logic [2:0] {
        SXR_OP_NONE,
        SXR_OP_RETURN,
        SXR_OP_ROTL,
        SXR_OP_ROTR,
        SXR_OP_SLEEP,
        SXR_OP_LITSUB
    } sxr_op_e;
    typedef struct packed {
        logic carry;
        logic nibble;
        logic zero;
        logic timeout;
        logic powerdown;
    } sxr_flags_s;
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } sxr_fwrite_s;
endpackage

// [tb_sxr_exec.sv]
// self-checking bench for the instruction executor
`timescale 1ns/1ps
module tb_sxr_exec import sxr_pkg::*;;
    // ****************
    // stimulus and checks
    // ****************
    logic i_clock = 1'h0;
    logic i_reset_n = 1'h0;
    logic i_valid = 1'h0;
    logic [13:0] i_opcode = 14'h0000;
    logic [7:0] i_file_data = 8'h00;
    logic [14:0] i_stack_head_value = 15'h0000;
    logic o_pop, o_fetch_stall, o_pc_load, o_watchdog_clear, o_sleep;
    logic [14:0] o_pc;
    logic [7:0] o_w;
    sxr_fwrite_s o_fwrite;
    sxr_flags_s o_flags;
    int err_count = 0;
    int check_count = 0;
    always #2 i_clock = ~i_clock;
    sxr_exec i_sxr_exec (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_valid(i_valid),
        .i_opcode(i_opcode),
        .i_file_data(i_file_data),
        .i_stack_head_value(i_stack_head_value),
        .o_pop(o_pop),
        .o_fetch_stall(o_fetch_stall),
        .o_pc(o_pc),
        .o_pc_load(o_pc_load),
        .o_w(o_w),
        .o_fwrite(o_fwrite),
        .o_flags(o_flags),
        .o_watchdog_clear(o_watchdog_clear),
        .o_sleep(o_sleep)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // inputs change 1 ns after an edge; results are read 1 ns after the next
    task automatic step(input logic v, input logic [13:0] op, input logic [7:0] fd);
        i_valid = v;
        i_opcode = op;
        i_file_data = fd;
        @(posedge i_clock);
        #1;
    endtask
    task automatic t_sub();
        step(1'h1, 14'h3C00, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h001F);
        step(1'h1, 14'h3C05, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h051B);
        step(1'h1, 14'h3C03, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'hFE03);
        // carry and nibble carry disagree in both directions
        step(1'h1, 14'h3C0F, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h110B);
        step(1'h1, 14'h3C20, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h0F13);
        step(1'h1, 14'h3C0D, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'hFE03);
    endtask
    task automatic t_rot();
        step(1'h1, 14'h0DA5, 8'hE6);
        chk(o_fwrite, 16'hA5CC);
        chk({o_w, 3'h0, o_flags}, 16'hFE13);
        step(1'h1, 14'h0C10, 8'h01);
        chk({o_w, 2'h0, o_fwrite.en, o_flags}, 16'h8013);
        step(1'h1, 14'h0D10, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h0103);
        step(1'h1, 14'h0C90, 8'h81);
        chk(o_fwrite, 16'h9040);
    endtask
    task automatic t_sleep();
        step(1'h1, 14'h0063, 8'h00);
        chk({o_sleep, o_watchdog_clear, 9'h0, o_flags}, 16'hC012);
    endtask
    task automatic t_ret(input logic [13:0] op, input logic [14:0] s, input logic [7:0] w);
        i_stack_head_value = s;
        step(1'h1, op, 8'h00);
        chk({o_pop, o_pc}, {1'h1, s});
        chk({o_pc_load, o_fetch_stall}, 16'h0003);
        step(1'h1, 14'h3C00, 8'h00);
        chk({o_w, 3'h0, o_pc_load, o_watchdog_clear, o_pop, o_fetch_stall, o_sleep},
            {w, 8'h00});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #4000;
        err_count++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge i_clock);
        #1;
        i_reset_n = 1'h1;
        chk({o_w, 3'h0, o_flags}, 16'h0003);
        t_sub();
        t_rot();
        t_sleep();
        t_ret(14'h0012, 15'h5A3C, 8'h01);
        t_ret(14'h0013, 15'h2C5A, 8'h01);
        // an opcode without valid must leave everything alone
        step(1'h0, 14'h3C01, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h0112);
        // a valid slot after the bubble and the idle slot is taken again
        step(1'h1, 14'h3C01, 8'h00);
        chk({o_w, 3'h0, o_flags}, 16'h001E);
        stop_test();
    end
endmodule // tb_sxr_exec
